// [control_net_pkg.sv]
package control_net_pkg;
   // register indices on the plain register port
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_TMR = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   // configuration field positions
   localparam int CFG_SVC_LSB = 0;
   localparam int CFG_RETRY_LSB = 2;
   localparam int CFG_REPEAT_LSB = 6;
   // status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_DROP = 3;
   localparam int ST_DUP = 4;
   localparam int ST_TID_LSB = 8;
   // reset values
   localparam logic [15:0] TMR_RESET = 16'h0400;
   localparam logic [3:0] RETRY_RESET = 4'h3;
   localparam logic [3:0] REPEAT_RESET = 4'h3;
   // datagram header
   localparam logic [1:0] VERSION = 2'h0;
   localparam logic [1:0] PK_TRANSPORT = 2'h0;
   localparam logic [1:0] PK_SESSION = 2'h1;
   localparam logic [1:0] PK_AUTH = 2'h2;
   localparam logic [1:0] PK_PRESENT = 2'h3;
   localparam logic [1:0] AM_BCAST = 2'h0;
   localparam logic [1:0] AM_GROUP = 2'h1;
   localparam logic [1:0] AM_NODE = 2'h2;
   localparam logic [1:0] AM_UID = 2'h3;
   // address and domain byte counts
   localparam logic [3:0] ALEN_BCAST = 4'h3;
   localparam logic [3:0] ALEN_GROUP = 4'h3;
   localparam logic [3:0] ALEN_NODE = 4'h4;
   localparam logic [3:0] ALEN_GACK = 4'h5;
   localparam logic [3:0] ALEN_UID = 4'h9;
   localparam logic [2:0] DLEN_0 = 3'h0;
   localparam logic [2:0] DLEN_1 = 3'h1;
   localparam logic [2:0] DLEN_2 = 3'h3;
   localparam logic [2:0] DLEN_3 = 3'h6;
   localparam int DOM_MAX = 6;
   localparam int PRE_BYTES = 16;
   localparam logic [7:0] DOMAIN_WIDE_SUBNET = 8'h00;
   typedef enum logic [1:0]
   {
      SVC_UNACK = 2'b00,
      SVC_ACK = 2'b01,
      SVC_REPEAT = 2'b10,
      SVC_RSVD = 2'b11
   } svc_e;
endpackage

// [addr_len_decode.sv]
module addr_len_decode
(
   input wire logic [1:0] amode,
   input wire logic gack,
   input wire logic [1:0] dcode,
   output logic [3:0] alen,
   output logic [2:0] dbytes
);
   always_comb
   begin
      unique case (amode)
         control_net_pkg::AM_BCAST: alen = control_net_pkg::ALEN_BCAST;
         control_net_pkg::AM_GROUP: alen = control_net_pkg::ALEN_GROUP;
         control_net_pkg::AM_NODE: alen = gack ? control_net_pkg::ALEN_GACK
                                               : control_net_pkg::ALEN_NODE;
         control_net_pkg::AM_UID: alen = control_net_pkg::ALEN_UID;
      endcase
      unique case (dcode)
         2'h0: dbytes = control_net_pkg::DLEN_0;
         2'h1: dbytes = control_net_pkg::DLEN_1;
         2'h2: dbytes = control_net_pkg::DLEN_2;
         2'h3: dbytes = control_net_pkg::DLEN_3;
      endcase
   end
endmodule

// [control_net_datagram_framer.sv]
module control_net_datagram_framer #(
   parameter int PL_MAX = 64,
   parameter int DUP_N = 4
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic tx_start,
   output logic tx_idle,
   input wire logic [1:0] tx_pkind,
   input wire logic [1:0] tx_amode,
   input wire logic tx_gack,
   input wire logic [1:0] tx_dcode,
   input wire logic [7:0] tx_src_subnet,
   input wire logic [6:0] tx_src_node,
   input wire logic [7:0] tx_dst_subnet,
   input wire logic [6:0] tx_dst_node,
   input wire logic [7:0] tx_group,
   input wire logic [6:0] tx_member,
   input wire logic [47:0] tx_uid,
   input wire logic [47:0] tx_domain,
   input wire logic [7:0] tx_dest_count,
   input wire logic tx_pl_valid,
   input wire logic [7:0] tx_pl_data,
   input wire logic tx_pl_last,
   output logic tx_pl_ready,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   input wire logic out_ready,
   input wire logic ack_in,
   output logic [3:0] tx_tid,
   output logic tx_done,
   output logic tx_fail,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_last,
   output logic rx_hdr_valid,
   output logic [1:0] rx_pkind,
   output logic [1:0] rx_amode,
   output logic rx_gack,
   output logic [71:0] rx_addr,
   output logic [47:0] rx_domain,
   output logic rx_pl_valid,
   output logic [7:0] rx_pl_data,
   output logic rx_pl_last,
   output logic rx_done,
   output logic rx_drop
);
   if (PL_MAX < 1 || PL_MAX > 4096 || DUP_N < 1 || DUP_N > 256)
   begin : g_chk
      $error("unsupported PL_MAX or DUP_N");
   end

   typedef enum logic [2:0]
   {
      T_IDLE = 3'b000,
      T_LOAD = 3'b001,
      T_SEND = 3'b010,
      T_WAIT = 3'b011,
      T_GAP = 3'b100
   } tx_st_e;

   typedef struct packed {
      logic [1:0] svc;
      logic [3:0] retry;
      logic [3:0] repeat_n;
      logic [15:0] ttime;
      logic done_f;
      logic fail_f;
      logic drop_f;
      logic dup_f;
      logic [31:0] rd;
      tx_st_e st;
      logic [127:0] pre;
      logic [4:0] hlen;
      logic [15:0] plen;
      logic [15:0] idx;
      logic [PL_MAX-1:0][7:0] mem;
      logic bcast;
      logic [3:0] left;
      logic [7:0] acks;
      logic [7:0] dcnt;
      logic [15:0] tmr;
      logic [3:0] tid;
      logic ov;
      logic [7:0] od;
      logic ol;
      logic done_p;
      logic fail_p;
      logic [127:0] rbuf;
      logic [4:0] rcnt;
      logic rpay;
      logic rfirst;
      logic rbad;
      logic rdup;
      logic [DUP_N-1:0][19:0] dtab;
      logic [7:0] dptr;
      logic hv;
      logic [1:0] rpk;
      logic [1:0] ram;
      logic rga;
      logic [71:0] radr;
      logic [47:0] rdom;
      logic pv;
      logic [7:0] pd;
      logic pl;
      logic rdone;
      logic rdrop;
   } state_s;

   state_s r_q;
   state_s r_d;
   logic [3:0] t_alen;
   logic [2:0] t_dbytes;
   logic [3:0] r_alen;
   logic [2:0] r_dbytes;
   logic r_gack;
   logic [4:0] r_need;
   logic [71:0] t_addr;
   logic [47:0] t_dom;
   logic [7:0] t_hdr;
   logic [127:0] t_sh;
   logic [15:0] t_total;
   logic [19:0] key;
   logic hit;

   // ==========================================================
   // header layout lookups
   addr_len_decode u_tx_len (
      .amode(tx_amode),
      .gack(tx_gack),
      .dcode(tx_dcode),
      .alen(t_alen),
      .dbytes(t_dbytes)
   );

   // mode 2 layout follows the flag of byte two, as seen live or stored
   assign r_gack = (r_q.rcnt == 5'h2) ? !in_data[7] : !r_q.rbuf[111];
   addr_len_decode u_rx_len (
      .amode(r_q.rbuf[123:122]),
      .gack(r_gack),
      .dcode(r_q.rbuf[121:120]),
      .alen(r_alen),
      .dbytes(r_dbytes)
   );
   assign r_need = 5'h1 + {1'b0, r_alen} + {2'b0, r_dbytes};

   // ==========================================================
   // datagram assembly
   always_comb
   begin
      t_hdr = {control_net_pkg::VERSION, tx_pkind, tx_amode, tx_dcode};
      unique case (tx_amode)
         control_net_pkg::AM_BCAST: t_addr = {tx_src_subnet, 1'b1, tx_src_node, tx_dst_subnet,
                                              48'h0};
         control_net_pkg::AM_GROUP: t_addr = {tx_src_subnet, 1'b1, tx_src_node, tx_group,
                                              48'h0};
         control_net_pkg::AM_NODE: t_addr = tx_gack
            ? {tx_src_subnet, 1'b0, tx_member, tx_dst_subnet, 1'b1, tx_dst_node, tx_group,
               32'h0}
            : {tx_src_subnet, 1'b1, tx_src_node, tx_dst_subnet, 1'b1, tx_dst_node,
               40'h0};
         control_net_pkg::AM_UID: t_addr = {tx_src_subnet, 1'b1, tx_src_node, tx_dst_subnet,
                                            tx_uid};
      endcase
      t_dom = tx_domain << (8 * (control_net_pkg::DOM_MAX - int'(t_dbytes)));
      t_sh = r_q.pre << (8 * int'(r_q.idx[3:0]));
      t_total = {11'h0, r_q.hlen} + r_q.plen;
      key = {1'b0, r_q.rbuf[119:112], r_q.rbuf[110:104], in_data[3:0]};
      hit = 1'b0;
      for (int i = 0; i < DUP_N; i++)
      begin
         if (r_q.dtab[i][19] && r_q.dtab[i][18:0] == {key[18:0]})
         begin
            hit = 1'b1;
         end
      end
   end

   // ==========================================================
   // next state
   always_comb
   begin
      r_d = r_q;
      r_d.done_p = 1'b0;
      r_d.fail_p = 1'b0;
      r_d.hv = 1'b0;
      r_d.pv = 1'b0;
      r_d.pl = 1'b0;
      r_d.rdone = 1'b0;
      r_d.rdrop = 1'b0;

      // register port; sticky flags clear first so events below win
      if (reg_wr)
      begin
         unique case (reg_addr)
            control_net_pkg::REG_CFG:
            begin
               r_d.svc = reg_wdata[control_net_pkg::CFG_SVC_LSB +: 2];
               r_d.retry = reg_wdata[control_net_pkg::CFG_RETRY_LSB +: 4];
               r_d.repeat_n = reg_wdata[control_net_pkg::CFG_REPEAT_LSB +: 4];
            end
            control_net_pkg::REG_TMR: r_d.ttime = reg_wdata[15:0];
            control_net_pkg::REG_STAT:
            begin
               r_d.done_f = r_q.done_f & !reg_wdata[control_net_pkg::ST_DONE];
               r_d.fail_f = r_q.fail_f & !reg_wdata[control_net_pkg::ST_FAIL];
               r_d.drop_f = r_q.drop_f & !reg_wdata[control_net_pkg::ST_DROP];
               r_d.dup_f = r_q.dup_f & !reg_wdata[control_net_pkg::ST_DUP];
            end
            default: ;
         endcase
      end
      r_d.rd = 32'h0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            control_net_pkg::REG_CFG:
            begin
               r_d.rd[control_net_pkg::CFG_SVC_LSB +: 2] = r_q.svc;
               r_d.rd[control_net_pkg::CFG_RETRY_LSB +: 4] = r_q.retry;
               r_d.rd[control_net_pkg::CFG_REPEAT_LSB +: 4] = r_q.repeat_n;
            end
            control_net_pkg::REG_TMR: r_d.rd[15:0] = r_q.ttime;
            control_net_pkg::REG_STAT:
            begin
               r_d.rd[control_net_pkg::ST_BUSY] = r_q.st != T_IDLE;
               r_d.rd[control_net_pkg::ST_DONE] = r_q.done_f;
               r_d.rd[control_net_pkg::ST_FAIL] = r_q.fail_f;
               r_d.rd[control_net_pkg::ST_DROP] = r_q.drop_f;
               r_d.rd[control_net_pkg::ST_DUP] = r_q.dup_f;
               r_d.rd[control_net_pkg::ST_TID_LSB +: 4] = r_q.tid;
            end
            default: ;
         endcase
      end

      // transmit side
      if (r_q.ov && out_ready)
      begin
         r_d.ov = 1'b0;
      end
      unique case (r_q.st)
         T_IDLE:
         begin
            if (tx_start)
            begin
               r_d.pre = {t_hdr, t_addr, 48'h0} | ({t_dom, 80'h0} >> (8 * (1 + int'(t_alen))));
               r_d.hlen = 5'h1 + {1'b0, t_alen} + {2'b0, t_dbytes};
               r_d.bcast = tx_amode == control_net_pkg::AM_BCAST;
               r_d.dcnt = tx_dest_count;
               r_d.plen = 16'h0;
               r_d.tid = r_q.tid + 4'h1;
               // any address mode with any service
               r_d.left = (r_q.svc == control_net_pkg::SVC_REPEAT && r_q.repeat_n != 4'h0)
                  ? r_q.repeat_n - 4'h1 : r_q.retry;
               r_d.st = T_LOAD;
            end
         end
         T_LOAD:
         begin
            if (tx_pl_valid)
            begin
               r_d.mem[r_q.plen] = tx_pl_data;
               r_d.plen = r_q.plen + 16'h1;
               if (tx_pl_last || r_q.plen == 16'(PL_MAX - 1))
               begin
                  r_d.idx = 16'h0;
                  r_d.acks = 8'h0;
                  r_d.st = T_SEND;
               end
            end
         end
         T_SEND:
         begin
            if (!r_q.ov || out_ready)
            begin
               if (r_q.idx == t_total)
               begin
                  r_d.tmr = r_q.ttime;
                  unique case (r_q.svc)
                     control_net_pkg::SVC_ACK: r_d.st = T_WAIT;
                     control_net_pkg::SVC_REPEAT:
                     begin
                        r_d.st = (r_q.left != 4'h0) ? T_GAP : T_IDLE;
                        r_d.done_p = r_q.left == 4'h0;
                     end
                     default:
                     begin
                        r_d.st = T_IDLE;
                        r_d.done_p = 1'b1;
                     end
                  endcase
               end
               else
               begin
                  r_d.ov = 1'b1;
                  r_d.od = (r_q.idx < {11'h0, r_q.hlen}) ? t_sh[127:120]
                     : r_q.mem[r_q.idx - {11'h0, r_q.hlen}];
                  r_d.ol = r_q.idx == t_total - 16'h1;
                  r_d.idx = r_q.idx + 16'h1;
               end
            end
         end
         T_WAIT:
         begin
            r_d.tmr = r_q.tmr - 16'h1;
            if (ack_in && (r_q.bcast || r_q.acks + 8'h1 >= r_q.dcnt))
            begin
               r_d.st = T_IDLE;
               r_d.done_p = 1'b1;
            end
            else if (ack_in)
            begin
               r_d.acks = r_q.acks + 8'h1;
            end
            else if (r_q.tmr == 16'h0)
            begin
               if (r_q.left != 4'h0)
               begin
                  r_d.left = r_q.left - 4'h1;
                  r_d.idx = 16'h0;
                  r_d.st = T_SEND;
               end
               else
               begin
                  r_d.st = T_IDLE;
                  r_d.fail_p = 1'b1;
               end
            end
         end
         T_GAP:
         begin
            r_d.tmr = r_q.tmr - 16'h1;
            if (r_q.tmr == 16'h0)
            begin
               r_d.left = r_q.left - 4'h1;
               r_d.idx = 16'h0;
               r_d.st = T_SEND;
            end
         end
         default: r_d.st = T_IDLE;
      endcase
      if (r_d.done_p)
      begin
         r_d.done_f = 1'b1;
      end
      if (r_d.fail_p)
      begin
         r_d.fail_f = 1'b1;
      end

      // receive side
      if (in_valid)
      begin
         if (!r_q.rpay)
         begin
            r_d.rbuf[127 - 8 * int'(r_q.rcnt) -: 8] = in_data;
            r_d.rcnt = r_q.rcnt + 5'h1;
            if (r_q.rcnt == 5'h0)
            begin
               r_d.rbad = in_data[7:6] != control_net_pkg::VERSION;
               r_d.rdup = 1'b0;
            end
            if (r_q.rcnt != 5'h0 && r_q.rcnt + 5'h1 == r_need)
            begin
               r_d.rpay = 1'b1;
               r_d.rfirst = 1'b1;
               r_d.hv = !r_q.rbad;
               r_d.rpk = r_q.rbuf[125:124];
               r_d.ram = r_q.rbuf[123:122];
               r_d.rga = r_gack;
               r_d.radr = r_d.rbuf[119:48] & ~(72'hff_ffff_ffff_ffff_ffff >> (8 * int'(r_alen)));
               r_d.rdom = r_d.rbuf[127 - 8 * (1 + int'(r_alen)) -: 48]
                  >> (8 * (control_net_pkg::DOM_MAX - int'(r_dbytes)));
            end
            if (in_last)
            begin
               r_d.rcnt = 5'h0;
               r_d.rpay = 1'b0;
               if (r_q.rcnt == 5'h0 || r_q.rcnt + 5'h1 != r_need || r_q.rbad)
               begin
                  r_d.rdrop = 1'b1;
                  r_d.hv = 1'b0;
               end
               else
               begin
                  r_d.rdone = 1'b1;
               end
            end
         end
         else
         begin
            r_d.rfirst = 1'b0;
            if (r_q.rfirst && !r_q.rbad)
            begin
               if (hit)
               begin
                  r_d.rdup = 1'b1;
               end
               else
               begin
                  r_d.dtab[r_q.dptr] = {1'b1, key[18:0]};
                  r_d.dptr = (r_q.dptr == 8'(DUP_N - 1)) ? 8'h0 : r_q.dptr + 8'h1;
               end
            end
            r_d.pv = !r_q.rbad && !r_d.rdup;
            r_d.pd = in_data;
            r_d.pl = in_last;
            if (in_last)
            begin
               r_d.rcnt = 5'h0;
               r_d.rpay = 1'b0;
               r_d.rdone = !r_q.rbad && !r_d.rdup;
               r_d.rdrop = r_q.rbad;
            end
         end
      end
      if (r_d.rdrop)
      begin
         r_d.drop_f = 1'b1;
      end
      if (r_d.rdup && !r_q.rdup)
      begin
         r_d.dup_f = 1'b1;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         r_q <= '0;
         r_q.st <= T_IDLE;
         r_q.svc <= control_net_pkg::SVC_UNACK;
         r_q.retry <= control_net_pkg::RETRY_RESET;
         r_q.repeat_n <= control_net_pkg::REPEAT_RESET;
         r_q.ttime <= control_net_pkg::TMR_RESET;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rdata = r_q.rd;
   assign tx_idle = r_q.st == T_IDLE;
   assign tx_pl_ready = r_q.st == T_LOAD;
   assign out_valid = r_q.ov;
   assign out_data = r_q.od;
   assign out_last = r_q.ol;
   assign tx_tid = r_q.tid;
   assign tx_done = r_q.done_p;
   assign tx_fail = r_q.fail_p;
   assign rx_hdr_valid = r_q.hv;
   assign rx_pkind = r_q.rpk;
   assign rx_amode = r_q.ram;
   assign rx_gack = r_q.rga;
   assign rx_addr = r_q.radr;
   assign rx_domain = r_q.rdom;
   assign rx_pl_valid = r_q.pv;
   assign rx_pl_data = r_q.pd;
   assign rx_pl_last = r_q.pl;
   assign rx_done = r_q.rdone;
   assign rx_drop = r_q.rdrop;
endmodule

// [framer_sva.sv]
module framer_sva #(
   parameter int PL_MAX = 64,
   parameter int DUP_N = 4
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic tx_start,
   input wire logic tx_idle,
   input wire logic [3:0] tx_tid,
   input wire logic tx_done,
   input wire logic tx_fail,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   input wire logic out_last,
   input wire logic out_ready,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_last,
   input wire logic rx_hdr_valid,
   input wire logic [1:0] rx_amode,
   input wire logic rx_gack,
   input wire logic [71:0] rx_addr,
   input wire logic rx_pl_valid,
   input wire logic [7:0] rx_pl_data,
   input wire logic rx_pl_last,
   input wire logic rx_done,
   input wire logic rx_drop
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // start of frame tracking and checks
   logic sof_q;
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         sof_q <= 1'b1;
      else if (out_valid && out_ready)
         sof_q <= out_last;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
      && $stable(out_last)) else $error("output byte changed while stalled");
   a_hdr_version: assert property (out_valid && sof_q |-> out_data[7:6] == 2'h0)
      else $error("header version not zero");
   a_tid_step: assert property (tx_idle && tx_start |=> !tx_idle && tx_tid == $past(tx_tid) + 4'h1)
      else $error("start not taken");
   a_end_excl: assert property (!(tx_done && tx_fail)) else $error("done with fail");
   a_rx_end: assert property (rx_done || rx_drop |-> $past(in_valid && in_last))
      else $error("receive end without last byte");
   a_rx_excl: assert property (!(rx_done && rx_drop)) else $error("done with drop");
   a_pl_echo: assert property (rx_pl_valid |-> $past(in_valid) && rx_pl_data == $past(in_data)
      && rx_pl_last == $past(in_last)) else $error("payload echo wrong");
   a_gack_bit: assert property (rx_hdr_valid && rx_amode == control_net_pkg::AM_NODE
      |-> rx_gack == !rx_addr[63]) else $error("layout select wrong");
   a_bcast_len: assert property (rx_hdr_valid && rx_amode == control_net_pkg::AM_BCAST
      |-> rx_addr[47:0] == 48'h0) else $error("broadcast address too long");
endmodule
bind control_net_datagram_framer framer_sva #(.PL_MAX(PL_MAX), .DUP_N(DUP_N)) chk_i (.*);

// [net_peer.sv]
module net_peer
(
   input wire logic ref_clk,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   input wire logic out_last,
   output logic out_ready,
   output logic ack_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // frame capture and acknowledgements
   logic [7:0] q[$];
   logic slow = 1'b0;
   int frames = 0, acks = 0, pend = 0, dly = 0;
   initial
   begin
      out_ready = 1'b0;
      ack_in = 1'b0;
   end
   always @(posedge ref_clk)
   begin
      out_ready <= slow ? ~out_ready : 1'b1;
      ack_in <= 1'b0;
      if (out_valid && out_ready)
      begin
         q.push_back(out_data);
         frames <= frames + int'(out_last);
      end
      if (out_valid && out_ready && out_last)
      begin
         pend <= acks;
         dly <= 4;
      end
      else if (dly != 0)
         dly <= dly - 1;
      else if (pend != 0 && !ack_in)
      begin
         ack_in <= 1'b1;
         pend <= pend - 1;
      end
   end
endmodule

// [control_net_datagram_framer_tb.sv]
module control_net_datagram_framer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, tx_start = 0, tx_gack = 0;
   logic tx_pl_valid = 0, tx_pl_last = 0, in_valid = 0, in_last = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [1:0] tx_pkind = 2'h0, tx_amode = 2'h0, tx_dcode = 2'h0;
   logic [7:0] tx_src_subnet = 8'h12, tx_dst_subnet = 8'h56, tx_group = 8'h9a;
   logic [6:0] tx_src_node = 7'h34, tx_dst_node = 7'h78, tx_member = 7'h2b;
   logic [47:0] tx_uid = 48'h0a1b2c3d4e5f, tx_domain = 48'h112233445566;
   logic [7:0] tx_dest_count = 8'h1, tx_pl_data = 8'h0, in_data = 8'h0;
   logic tx_idle, tx_pl_ready, out_valid, out_last, out_ready, ack_in, tx_done, tx_fail;
   logic rx_hdr_valid, rx_gack, rx_pl_valid, rx_pl_last, rx_done, rx_drop;
   logic [31:0] reg_rdata;
   logic [7:0] out_data, rx_pl_data;
   logic [3:0] tx_tid;
   logic [1:0] rx_pkind, rx_amode;
   logic [71:0] rx_addr;
   logic [47:0] rx_domain;
   int n_mismatch = 0, compares = 0, nd = 0, nf = 0, nh = 0, nr = 0, np = 0, nx = 0, sd = 0, sf = 0;
   logic [7:0] ex[$];
   always #4 ref_clk = ~ref_clk;
   control_net_datagram_framer #(.PL_MAX(4), .DUP_N(2)) uut (.*);
   net_peer peer (.ref_clk, .out_valid, .out_data, .out_last, .out_ready, .ack_in);
   always @(posedge ref_clk)
   begin
      nd <= nd + int'(tx_done === 1'b1);
      nf <= nf + int'(tx_fail === 1'b1);
      nh <= nh + int'(rx_hdr_valid === 1'b1);
      nr <= nr + int'(rx_done === 1'b1);
      np <= np + int'(rx_pl_valid === 1'b1);
      nx <= nx + int'(rx_drop === 1'b1);
   end
   // ====================
   // shared tasks
   task automatic chk(string s, logic [71:0] e, logic [71:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", 72'(e), 72'(reg_rdata));
      @(posedge ref_clk);
   endtask
   task automatic wait_end(int c);
      int k;
      k = 0;
      while (nd + nf == c)
      begin
         @(posedge ref_clk);
         k++;
         if (k > 4000)
         begin
            n_mismatch++;
            wrap_up();
         end
      end
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic send(logic [1:0] am, logic gk, logic [1:0] pk, logic [1:0] dc, logic [7:0] p);
      int c;
      c = nd + nf;
      tx_amode <= am;
      tx_gack <= gk;
      tx_pkind <= pk;
      tx_dcode <= dc;
      tx_start <= 1'b1;
      @(posedge ref_clk);
      tx_start <= 1'b0;
      tx_pl_valid <= 1'b1;
      tx_pl_data <= p;
      tx_pl_last <= 1'b1;
      @(negedge ref_clk);
      chk("tx_pl_ready", 72'(1), 72'(tx_pl_ready));
      @(posedge ref_clk);
      tx_pl_valid <= 1'b0;
      tx_pl_data <= ~p;
      wait_end(c);
   endtask
   function automatic void mk(logic [1:0] am, logic gk, logic [1:0] pk, logic [1:0] dc,
      logic [7:0] p);
      int n;
      ex = {};
      ex.push_back({2'h0, pk, am, dc});
      ex.push_back(tx_src_subnet);
      if (am == control_net_pkg::AM_NODE && gk)
         ex.push_back({1'b0, tx_member});
      else
         ex.push_back({1'b1, tx_src_node});
      ex.push_back(am == control_net_pkg::AM_GROUP ? tx_group : tx_dst_subnet);
      if (am == control_net_pkg::AM_NODE)
         ex.push_back({1'b1, tx_dst_node});
      if (am == control_net_pkg::AM_NODE && gk)
         ex.push_back(tx_group);
      if (am == control_net_pkg::AM_UID)
         for (int i = 5; i >= 0; i--)
            ex.push_back(tx_uid[8*i+:8]);
      n = dc == 2'h3 ? 6 : dc == 2'h2 ? 3 : int'(dc);
      for (int i = n - 1; i >= 0; i--)
         ex.push_back(tx_domain[8*i+:8]);
      ex.push_back(p);
   endfunction
   task automatic res(int fr, int dn, int fl);
      chk("frames", 72'(fr), 72'(peer.frames));
      chk("tx_done", 72'(dn), 72'(nd - sd));
      chk("tx_fail", 72'(fl), 72'(nf - sf));
      sd = nd;
      sf = nf;
      peer.frames = 0;
      peer.q = {};
   endtask
   task automatic rxs();
      for (int i = 0; i < ex.size(); i++)
      begin
         in_valid <= 1'b1;
         in_data <= ex[i];
         in_last <= i == ex.size() - 1;
         @(posedge ref_clk);
      end
      in_valid <= 1'b0;
      in_last <= 1'b0;
      in_data <= ~in_data;
      repeat (3) @(posedge ref_clk);
   endtask
   // ====================
   // scenarios
   task automatic t_regs();
      rd(control_net_pkg::REG_CFG, 32'hcc);
      rd(control_net_pkg::REG_TMR, 32'h400);
      rd(control_net_pkg::REG_STAT, 32'h0);
      wr(4'hf, 32'hffff);
      rd(4'hf, 32'h0);
   endtask
   task automatic t_unack();
      logic [1:0] am;
      for (int i = 0; i < 5; i++)
      begin
         am = i < 2 ? 2'(i) : i < 4 ? 2'h2 : 2'h3;
         peer.slow = i[0];
         tx_dst_subnet <= i == 0 ? control_net_pkg::DOMAIN_WIDE_SUBNET : 8'h56;
         send(am, i == 3, 2'(i), 2'(i), 8'ha0 + 8'(i));
         mk(am, i == 3, 2'(i), 2'(i), 8'ha0 + 8'(i));
         chk("frame size", 72'(ex.size()), 72'(peer.q.size()));
         for (int j = 0; j < ex.size() && j < peer.q.size(); j++)
            chk("frame byte", 72'(ex[j]), 72'(peer.q[j]));
         res(1, 1, 0);
      end
      peer.slow = 1'b0;
   endtask
   task automatic t_ack();
      wr(control_net_pkg::REG_TMR, 32'h14);
      wr(control_net_pkg::REG_CFG, 32'h5);
      peer.acks = 2;
      tx_dest_count <= 8'h2;
      send(control_net_pkg::AM_NODE, 1'b0, 2'h0, 2'h0, 8'h11);
      res(1, 1, 0);
      peer.acks = 0;
      send(control_net_pkg::AM_NODE, 1'b0, 2'h0, 2'h0, 8'h12);
      res(2, 0, 1);
      wr(control_net_pkg::REG_CFG, 32'h1);
      send(control_net_pkg::AM_GROUP, 1'b0, 2'h0, 2'h0, 8'h13);
      res(1, 0, 1);
      peer.acks = 2;
      tx_dest_count <= 8'h3;
      send(control_net_pkg::AM_BCAST, 1'b0, 2'h0, 2'h0, 8'h14);
      res(1, 1, 0);
   endtask
   task automatic t_rep();
      wr(control_net_pkg::REG_CFG, 32'h82);
      peer.acks = 1;
      send(control_net_pkg::AM_GROUP, 1'b0, 2'h0, 2'h0, 8'h15);
      res(2, 1, 0);
      rd(control_net_pkg::REG_STAT, 32'ha06);
      peer.acks = 0;
   endtask
   task automatic t_rx();
      mk(control_net_pkg::AM_BCAST, 1'b0, 2'h1, 2'h1, 8'h05);
      rxs();
      chk("rx_done", 72'(1), 72'(nr));
      chk("rx_pl_valid", 72'(1), 72'(np));
      chk("rx_pkind", 72'(1), 72'(rx_pkind));
      chk("rx_addr", {ex[1], ex[2], ex[3], 48'h0}, rx_addr);
      chk("rx_domain", 72'(48'h66), 72'(rx_domain));
      rxs();
      chk("dup rx_done", 72'(1), 72'(nr));
      chk("dup rx_pl_valid", 72'(1), 72'(np));
      mk(control_net_pkg::AM_NODE, 1'b1, 2'h0, 2'h0, 8'h06);
      rxs();
      chk("rx_gack", 72'(1), 72'(rx_gack));
      chk("rx_addr gack", {ex[1], ex[2], ex[3], ex[4], ex[5], 32'h0}, rx_addr);
      ex[0] = 8'h40;
      rxs();
      chk("rx_drop version", 72'(1), 72'(nx));
      mk(control_net_pkg::AM_UID, 1'b0, 2'h0, 2'h2, 8'h07);
      ex = ex[0:4];
      rxs();
      chk("rx_drop short", 72'(2), 72'(nx));
      chk("rx_hdr_valid", 72'(3), 72'(nh));
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_unack();
      t_ack();
      t_rep();
      t_rx();
      wrap_up();
   end
endmodule
